// ### hw/cpcap_top.sv
// Capability query responder, capacity mask banks and class association.
// Assumes software issues one query or register access per cycle as pulses.
//
// Functional notes
// [R1] Leaf 07H reports shared-resource control bit 15
// [R2] Leaf 10H sub 0 flags level resources
// [R3] Sub 0 other words read reserved zero
// [R4] Resource sub-leaf returns that resource's details
// [R5] First word 4:0 holds mask length minus one
// [R6] Last-level second word marks shared units
// [R7] Last-level third word bit 1 non-CPU agents
// [R8] Last-level third word bit 2 code/data split
// [R9] Third word bit 3 non-contiguous masks accepted
// [R10] Fourth word 15:0 highest class number
// [R11] Last-level third word bits 0, 31:4 reserved
// [R12] Second-level third word: bit 2, bit 3
// [R13] Second-level second word marks shared units
// [R14] One mask register per class, each level
// [R15] Mask banks shared by all sharers
// [R16] Per-processor association with common class field
// [R17] Software reads sub-leaves before configuring
// [R18] Association at 0C8FH, class bits 63:32
// [R19] Reset masks all ones, split off
// [R20] Mask registers at 0C90H..0D0FH, 0D10H..0D4FH
// [R21] Unknown sub-leaf returns zeros
`timescale 1ns/100ps
module cpcap_top
  import cpcap_pkg::*;
#(
  parameter int          LPS            = 2,
  parameter int          LL_MASK_W      = 16,
  parameter int          LL_CLASSES     = 16,
  parameter int          SL_MASK_W      = 8,
  parameter int          SL_CLASSES     = 8,
  parameter logic [31:0] LL_SHARED_UNITS = 32'h0000_c000,
  parameter logic [31:0] SL_SHARED_UNITS = 32'h0000_0000,
  parameter bit          LL_PRESENT     = 1'b1,
  parameter bit          SL_PRESENT     = 1'b1,
  parameter bit          LL_NONCPU      = 1'b1,
  parameter bit          LL_CDS         = 1'b1,
  parameter bit          LL_NONCONTIG   = 1'b0,
  parameter bit          SL_CDS         = 1'b1,
  parameter bit          SL_NONCONTIG   = 1'b0,
  parameter int          LP_W           = 1
)
(
  input  wire logic               clk,
  input  wire logic               rst_b,
  // Identification query
  input  wire logic               query_valid,
  input  wire logic [31:0]        query_leaf,
  input  wire logic [31:0]        query_subleaf,
  output logic                    query_done,
  output logic [31:0]             first_result_word,
  output logic [31:0]             second_result_word,
  output logic [31:0]             third_result_word,
  output logic [31:0]             fourth_result_word,
  // Register access
  input  wire logic               reg_valid,
  input  wire logic               reg_write,
  input  wire logic [LP_W-1:0]    reg_lp,
  input  wire logic [15:0]        reg_addr,
  input  wire logic [63:0]        reg_wdata,
  output logic                    reg_done,
  output logic [63:0]             reg_rdata,
  output logic                    reg_error,
  // Status towards the allocation logic
  output logic [LPS-1:0][31:0]    lp_class_of_service,
  output logic                    code_data_split
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  initial
  begin
    if (LL_MASK_W < 1 || LL_MASK_W > 32 || SL_MASK_W < 1 || SL_MASK_W > 32)
      $error("cpcap_top: mask width must be 1..32");
    if (LL_CLASSES < 1 || LL_CLASSES > 128 || SL_CLASSES < 1 || SL_CLASSES > 64)
      $error("cpcap_top: class count out of range");
    if (LPS < 1 || LPS > (1 << LP_W))
      $error("cpcap_top: processor count does not fit index");
    if ((LL_SHARED_UNITS >> LL_MASK_W) != 32'h0 || (SL_SHARED_UNITS >> SL_MASK_W) != 32'h0)
      $error("cpcap_top: shared units beyond mask length");
  end

  localparam int IDX_W = 7;

  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------
  logic rst_meta_b;
  logic rst_sync_b;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic                  query_done;
    logic [31:0]           w1;
    logic [31:0]           w2;
    logic [31:0]           w3;
    logic [31:0]           w4;
    logic                  reg_done;
    logic [63:0]           reg_rdata;
    logic                  reg_error;
    logic [LPS-1:0][31:0]  cls;
  } cpcap_state_t;

  cpcap_state_t st;
  cpcap_state_t next_st;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic             hit_assoc;
  logic             hit_ll;
  logic             hit_sl;
  logic [IDX_W-1:0] ll_idx;
  logic [IDX_W-1:0] sl_idx;
  logic [15:0]      ll_off;
  logic [15:0]      sl_off;

  always_comb
  begin
    hit_assoc = reg_addr == CPCAP_ADDR_ASSOC;  // [R18]
    hit_ll    = reg_addr >= CPCAP_ADDR_LL_FIRST && reg_addr <= CPCAP_ADDR_LL_LAST;  // [R20]
    hit_sl    = reg_addr >= CPCAP_ADDR_SL_FIRST && reg_addr <= CPCAP_ADDR_SL_LAST;  // [R20]
    ll_off    = reg_addr - CPCAP_ADDR_LL_FIRST;
    sl_off    = reg_addr - CPCAP_ADDR_SL_FIRST;
    ll_idx    = ll_off[IDX_W-1:0];
    sl_idx    = sl_off[IDX_W-1:0];
  end

  // ----------------------------------------
  // Mask banks, one per cache level
  // ----------------------------------------
  logic [LL_MASK_W-1:0] ll_rd;
  logic [SL_MASK_W-1:0] sl_rd;
  logic                 ll_ok;
  logic                 sl_ok;
  logic                 ll_wr;
  logic                 sl_wr;
  logic                 ll_resv;
  logic                 sl_resv;

  // Bits above the mask length are reserved and refuse the write
  always_comb
  begin
    ll_resv = LL_MASK_W < 64 && (reg_wdata >> LL_MASK_W) != 64'h0;
    sl_resv = SL_MASK_W < 64 && (reg_wdata >> SL_MASK_W) != 64'h0;
    ll_wr   = reg_valid && reg_write && hit_ll && ll_ok && !ll_resv && LL_PRESENT;
    sl_wr   = reg_valid && reg_write && hit_sl && sl_ok && !sl_resv && SL_PRESENT;
  end

  cpcap_mask_bank #(
    .MASK_W  (LL_MASK_W),
    .CLASSES (LL_CLASSES),
    .IDX_W   (IDX_W)
  ) u_last_level (
    .clk        (clk),
    .rst_sync_b (rst_sync_b),
    .wr_en      (ll_wr),
    .wr_idx     (ll_idx),
    .wr_data    (reg_wdata[LL_MASK_W-1:0]),
    .rd_idx     (ll_idx),
    .rd_data    (ll_rd),
    .rd_hit     (ll_ok)
  );

  cpcap_mask_bank #(
    .MASK_W  (SL_MASK_W),
    .CLASSES (SL_CLASSES),
    .IDX_W   (IDX_W)
  ) u_second_level (
    .clk        (clk),
    .rst_sync_b (rst_sync_b),
    .wr_en      (sl_wr),
    .wr_idx     (sl_idx),
    .wr_data    (reg_wdata[SL_MASK_W-1:0]),
    .rd_idx     (sl_idx),
    .rd_data    (sl_rd),
    .rd_hit     (sl_ok)
  );

  // ----------------------------------------
  // Capability words of each level
  // ----------------------------------------
  logic [31:0] ll_len_word;
  logic [31:0] ll_share_word;
  logic [31:0] ll_flag_word;
  logic [31:0] ll_cls_word;
  logic [31:0] sl_len_word;
  logic [31:0] sl_share_word;
  logic [31:0] sl_flag_word;
  logic [31:0] sl_cls_word;

  always_comb
  begin
    ll_len_word                       = 32'h0;
    ll_share_word                     = 32'h0;
    ll_flag_word                      = 32'h0;
    ll_cls_word                       = 32'h0;
    ll_len_word[CPCAP_LEN_W-1:0]      = CPCAP_LEN_W'(LL_MASK_W - 1);  // [R5]
    // Only units inside the mask length are reported
    ll_share_word                     = LL_SHARED_UNITS & (32'hffff_ffff >> (32 - LL_MASK_W));  // [R6]
    ll_flag_word[CPCAP_NONCPU_BIT]    = LL_NONCPU;  // [R7] [R11]
    ll_flag_word[CPCAP_CDS_BIT]       = LL_CDS;  // [R8]
    ll_flag_word[CPCAP_NONCONTIG_BIT] = LL_NONCONTIG;  // [R9]
    ll_cls_word[CPCAP_MAXCLS_W-1:0]   = CPCAP_MAXCLS_W'(LL_CLASSES - 1);  // [R10]
  end

  always_comb
  begin
    sl_len_word                       = 32'h0;
    sl_share_word                     = 32'h0;
    sl_flag_word                      = 32'h0;
    sl_cls_word                       = 32'h0;
    sl_len_word[CPCAP_LEN_W-1:0]      = CPCAP_LEN_W'(SL_MASK_W - 1);  // [R5]
    sl_share_word                     = SL_SHARED_UNITS & (32'hffff_ffff >> (32 - SL_MASK_W));  // [R13]
    sl_flag_word[CPCAP_CDS_BIT]       = SL_CDS;  // [R12]
    sl_flag_word[CPCAP_NONCONTIG_BIT] = SL_NONCONTIG;  // [R9] [R12]
    sl_cls_word[CPCAP_MAXCLS_W-1:0]   = CPCAP_MAXCLS_W'(SL_CLASSES - 1);  // [R10]
  end

  // ----------------------------------------
  // Query and register logic
  // ----------------------------------------
  always_comb
  begin
    next_st            = st;
    next_st.query_done = 1'b0;
    next_st.reg_done   = 1'b0;
    next_st.reg_error  = 1'b0;

    if (query_valid)
    begin
      next_st.query_done = 1'b1;
      next_st.w1 = 32'h0;  // [R3] [R21]
      next_st.w2 = 32'h0;
      next_st.w3 = 32'h0;
      next_st.w4 = 32'h0;
      if (query_leaf == CPCAP_LEAF_FEATURES && query_subleaf == CPCAP_SUB_ENUM)
        next_st.w2[CPCAP_SHARED_CTRL_BIT] = LL_PRESENT | SL_PRESENT;  // [R1]
      else if (query_leaf == CPCAP_LEAF_ALLOC)
      begin
        if (query_subleaf == CPCAP_SUB_ENUM)
        begin
          next_st.w2[CPCAP_RES_LAST[4:0]]   = LL_PRESENT;  // [R2]
          next_st.w2[CPCAP_RES_SECOND[4:0]] = SL_PRESENT;  // [R2]
        end
        else if (query_subleaf == CPCAP_RES_LAST && LL_PRESENT)  // [R4]
        begin
          next_st.w1 = ll_len_word;
          next_st.w2 = ll_share_word;
          next_st.w3 = ll_flag_word;
          next_st.w4 = ll_cls_word;
        end
        else if (query_subleaf == CPCAP_RES_SECOND && SL_PRESENT)  // [R4]
        begin
          next_st.w1 = sl_len_word;
          next_st.w2 = sl_share_word;
          next_st.w3 = sl_flag_word;
          next_st.w4 = sl_cls_word;
        end
      end
    end

    if (reg_valid)
    begin
      next_st.reg_done  = 1'b1;
      next_st.reg_rdata = 64'h0;
      if (int'(reg_lp) >= LPS)
        next_st.reg_error = 1'b1;
      else if (hit_assoc)
      begin
        // Low half reserved here; class field accepted up to 32 bits
        if (reg_write)
        begin
          if (reg_wdata[CPCAP_ASSOC_CLS_LSB-1:0] != 32'h0)
            next_st.reg_error = 1'b1;
          else
            next_st.cls[reg_lp] = reg_wdata[63:CPCAP_ASSOC_CLS_LSB];  // [R16] [R18]
        end
        else
          next_st.reg_rdata = {st.cls[reg_lp], 32'h0};  // [R18]
      end
      else if (hit_ll && ll_ok && LL_PRESENT)
      begin
        if (reg_write)
          next_st.reg_error = ll_resv;
        else
          next_st.reg_rdata = 64'(ll_rd);  // [R15]
      end
      else if (hit_sl && sl_ok && SL_PRESENT)
      begin
        if (reg_write)
          next_st.reg_error = sl_resv;
        else
          next_st.reg_rdata = 64'(sl_rd);  // [R15]
      end
      else
        next_st.reg_error = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      st <= '{default: '0};  // [R19]
    else
      st <= next_st;
  end

  // ----------------------------------------
  // Outputs straight from flip-flops, except code_data_split, which is tied low
  // ----------------------------------------
  assign query_done          = st.query_done;
  assign first_result_word   = st.w1;
  assign second_result_word  = st.w2;
  assign third_result_word   = st.w3;
  assign fourth_result_word  = st.w4;
  assign reg_done            = st.reg_done;
  assign reg_rdata           = st.reg_rdata;
  assign reg_error           = st.reg_error;
  assign lp_class_of_service = st.cls;
  // Remapping is out of scope; split stays disabled after reset
  assign code_data_split     = 1'b0;  // [R19]

endmodule : cpcap_top

// ### hw/cpcap_pkg.sv
// Constants for cache partition capability reporting and mask registers.
// Assumes a single core clock; all values are reset defaults or encodings.
package cpcap_pkg;

  // ----------------------------------------
  // Query leaves and sub-leaves
  // ----------------------------------------
  localparam logic [31:0] CPCAP_LEAF_FEATURES = 32'h0000_0007;
  localparam logic [31:0] CPCAP_LEAF_ALLOC    = 32'h0000_0010;
  localparam logic [31:0] CPCAP_SUB_ENUM      = 32'h0000_0000;
  localparam logic [31:0] CPCAP_RES_LAST      = 32'h0000_0001;
  localparam logic [31:0] CPCAP_RES_SECOND    = 32'h0000_0002;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CPCAP_SHARED_CTRL_BIT = 15;
  localparam int CPCAP_NONCPU_BIT      = 1;
  localparam int CPCAP_CDS_BIT         = 2;
  localparam int CPCAP_NONCONTIG_BIT   = 3;
  localparam int CPCAP_LEN_W           = 5;
  localparam int CPCAP_MAXCLS_W        = 16;
  localparam int CPCAP_ASSOC_CLS_LSB   = 32;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [15:0] CPCAP_ADDR_ASSOC     = 16'h0c8f;
  localparam logic [15:0] CPCAP_ADDR_LL_FIRST  = 16'h0c90;
  localparam logic [15:0] CPCAP_ADDR_LL_LAST   = 16'h0d0f;
  localparam logic [15:0] CPCAP_ADDR_SL_FIRST  = 16'h0d10;
  localparam logic [15:0] CPCAP_ADDR_SL_LAST   = 16'h0d4f;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [63:0] CPCAP_MASK_RESET  = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] CPCAP_ASSOC_RESET = 64'h0000_0000_0000_0000;

endpackage : cpcap_pkg

// ### hw/cpcap_mask_bank.sv
// Bank of per-class capacity mask registers for one cache level.
// Assumes writes arrive from any sharer of that cache; one copy serves all.
`timescale 1ns/100ps
module cpcap_mask_bank
  import cpcap_pkg::*;
#(
  parameter int MASK_W  = 16,
  parameter int CLASSES = 16,
  parameter int IDX_W   = 7
)
(
  input  wire logic               clk,
  input  wire logic               rst_sync_b,
  input  wire logic               wr_en,
  input  wire logic [IDX_W-1:0]   wr_idx,
  input  wire logic [MASK_W-1:0]  wr_data,
  input  wire logic [IDX_W-1:0]   rd_idx,
  output logic      [MASK_W-1:0]  rd_data,
  output logic                    rd_hit
);

  initial
  begin
    if (CLASSES < 1 || CLASSES > (1 << IDX_W) || MASK_W < 1 || MASK_W > 32)
      $error("cpcap_mask_bank: unsupported parameters");
  end

  typedef struct packed {
    logic [CLASSES-1:0][MASK_W-1:0] mask;
  } cpcap_bank_t;

  cpcap_bank_t st;
  cpcap_bank_t next_st;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    if (wr_en && (int'(wr_idx) < CLASSES))
      next_st.mask[wr_idx] = wr_data;  // [R14] [R15]
  end

  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      st <= '{mask: {CLASSES{CPCAP_MASK_RESET[MASK_W-1:0]}}};  // [R19]
    else
      st <= next_st;
  end

  // Combinational read; the top registers the answer
  always_comb
  begin
    rd_hit  = int'(rd_idx) < CLASSES;
    rd_data = rd_hit ? st.mask[rd_idx] : '0;
  end

endmodule : cpcap_mask_bank

// ### dv/cpcap_checker.sv
// Port properties of the capability responder and its registers.
// Assumes the default capability parameters of the top module.
`timescale 1ns/100ps
module cpcap_checker
  import cpcap_pkg::*;
#(
  parameter int LPS  = 2,
  parameter int LP_W = 1
)
(
  input wire logic                 clk,
  input wire logic                 rst_b,
  input wire logic                 query_valid,
  input wire logic [31:0]          query_leaf,
  input wire logic [31:0]          query_subleaf,
  input wire logic                 query_done,
  input wire logic [31:0]          first_result_word,
  input wire logic [31:0]          second_result_word,
  input wire logic [31:0]          third_result_word,
  input wire logic [31:0]          fourth_result_word,
  input wire logic                 reg_valid,
  input wire logic                 reg_write,
  input wire logic [LP_W-1:0]      reg_lp,
  input wire logic [15:0]          reg_addr,
  input wire logic [63:0]          reg_wdata,
  input wire logic                 reg_done,
  input wire logic [63:0]          reg_rdata,
  input wire logic                 reg_error,
  input wire logic [LPS-1:0][31:0] lp_class_of_service,
  input wire logic                 code_data_split
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic alloc_q;
  assign alloc_q = query_valid && query_leaf == CPCAP_LEAF_ALLOC;

  a_query_answer: assert property (query_valid |=> query_done) else $error("query unanswered");
  a_done_cause: assert property (query_done |-> $past(query_valid)) else $error("stray query done");
  a_words_hold: assert property (
    !query_valid |=> $stable(first_result_word) && $stable(third_result_word))
    else $error("result words moved");
  a_feat_bit: assert property (
    query_valid && query_leaf == CPCAP_LEAF_FEATURES && query_subleaf == 32'h0 |=> second_result_word[15])
    else $error("shared control flag low");
  a_enum_words: assert property (
    alloc_q && query_subleaf == 32'h0 |=> first_result_word == 32'h0
    && third_result_word == 32'h0 && fourth_result_word == 32'h0 && second_result_word[0] == 1'b0)
    else $error("enumeration reserved words");
  a_res_reserved: assert property (
    alloc_q && (query_subleaf == 32'h1 || query_subleaf == 32'h2)
    |=> first_result_word[31:5] == 27'h0 && fourth_result_word[31:16] == 16'h0)
    else $error("resource reserved bits");
  a_unknown_zero: assert property (
    alloc_q && query_subleaf > 32'h2 |=> {first_result_word,
    second_result_word, third_result_word, fourth_result_word} == 128'h0) else $error("unknown sub-leaf");
  a_assoc_low: assert property (
    reg_valid && !reg_write && reg_addr == CPCAP_ADDR_ASSOC
    |=> reg_done && reg_rdata[31:0] == 32'h0) else $error("association low half");
  a_unmapped: assert property (
    reg_valid && !reg_write && reg_addr > CPCAP_ADDR_SL_LAST
    |=> reg_error && reg_rdata == 64'h0) else $error("unmapped read");
  a_err_pair: assert property (reg_error |-> reg_done) else $error("error without done");
  a_split_off: assert property (code_data_split == 1'b0) else $error("split enabled");
endmodule : cpcap_checker

bind cpcap_top cpcap_checker #(.LPS(LPS), .LP_W(LP_W)) i_cpcap_checker (.clk, .rst_b, .query_valid,
  .query_leaf, .query_subleaf, .query_done, .first_result_word, .second_result_word, .third_result_word,
  .fourth_result_word, .reg_valid, .reg_write, .reg_lp, .reg_addr, .reg_wdata, .reg_done, .reg_rdata,
  .reg_error, .lp_class_of_service, .code_data_split);

// ### dv/cpcap_sw_model.sv
// Software side: issues identification queries and register accesses.
// Assumes one request per call, taken at the edge after it is raised.
`timescale 1ns/100ps
module cpcap_sw_model
(
  input  wire logic clk,
  output logic      query_valid,
  output logic [31:0] query_leaf,
  output logic [31:0] query_subleaf,
  output logic      reg_valid,
  output logic      reg_write,
  output logic [0:0] reg_lp,
  output logic [15:0] reg_addr,
  output logic [63:0] reg_wdata
);
  initial
  begin
    query_valid = 1'b0;
    query_leaf = 32'h0;
    query_subleaf = 32'h0;
    reg_valid = 1'b0;
    reg_write = 1'b0;
    reg_lp = 1'b0;
    reg_addr = 16'h0;
    reg_wdata = 64'h0;
  end
  // Released leaf, sub-leaf, address and write-data lines show inverted data so stale values never match
  task automatic query(input logic [31:0] l, input logic [31:0] s);
    @(posedge clk);
    #1;
    query_valid = 1'b1;
    query_leaf = l;
    query_subleaf = s;
    @(posedge clk);
    #1;
    query_valid = 1'b0;
    query_leaf = ~l;
    query_subleaf = ~s;
  endtask : query
  task automatic access(input logic [0:0] lp, input logic w, input logic [15:0] a, input logic [63:0] d);
    @(posedge clk);
    #1;
    reg_valid = 1'b1;
    reg_write = w;
    reg_lp = lp;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_valid = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : access
endmodule : cpcap_sw_model

// ### dv/tb.sv
// Self-checking bench: driver notes expectations, monitor compares.
// Assumes default top parameters: 16-bit/16-class and 8-bit/8-class levels.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  import cpcap_pkg::*;
  logic clk, rst_b, query_valid, query_done, reg_valid, reg_write, reg_done, reg_error, code_data_split;
  logic [31:0] query_leaf, query_subleaf, first_result_word, second_result_word, third_result_word;
  logic [31:0] fourth_result_word, c;
  logic [0:0] reg_lp;
  logic [15:0] reg_addr;
  logic [63:0] reg_wdata, reg_rdata, d;
  logic [1:0][31:0] lp_class_of_service;
  logic [127:0] qexp[$];
  logic [65:0] rexp[$];
  logic [65:0] rexp_now, rgot;
  logic [127:0] words;
  assign words = {first_result_word, second_result_word, third_result_word, fourth_result_word};
  int err_total, checks_done, cyc, i, k;

  cpcap_top i_cpcap_top (.clk, .rst_b, .query_valid, .query_leaf, .query_subleaf, .query_done,
    .first_result_word, .second_result_word, .third_result_word, .fourth_result_word, .reg_valid,
    .reg_write, .reg_lp, .reg_addr, .reg_wdata, .reg_done, .reg_rdata, .reg_error,
    .lp_class_of_service, .code_data_split);
  cpcap_sw_model i_cpcap_sw_model (.clk, .query_valid, .query_leaf, .query_subleaf, .reg_valid,
    .reg_write, .reg_lp, .reg_addr, .reg_wdata);

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic q(input logic [31:0] s, input logic [127:0] e);
    qexp.push_back(e);
    i_cpcap_sw_model.query(CPCAP_LEAF_ALLOC, s);
  endtask : q
  task automatic r(input logic [0:0] lp, input logic w, input logic [15:0] a, input logic [63:0] wd,
                   input logic err, input logic [63:0] e);
    rexp.push_back({!w, err, e});
    i_cpcap_sw_model.access(lp, w, a, wd);
  endtask : r

  // ----------------------------------------
  // Monitor
  // ----------------------------------------
  always @(negedge clk)
  begin
    if (query_done === 1'b1)
      `CHK("query words", qexp.pop_front(), words)
    if (reg_done === 1'b1)
    begin
      rexp_now = rexp.pop_front();
      rgot = {rexp_now[65], reg_error, rexp_now[65] ? reg_rdata : 64'h0};
      `CHK("reg access", rexp_now[65] ? rexp_now : {1'b0, rexp_now[64], 64'h0}, rgot)
    end
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_total++;
      end_sim();
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    rst_b = 1'b0;
    void'($urandom(32'hd9bf3dcc));
    repeat (10) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clk);
    // Probe every resource before configuring it
    qexp.push_back({32'h0, 32'h8000, 64'h0});
    i_cpcap_sw_model.query(CPCAP_LEAF_FEATURES, CPCAP_SUB_ENUM);
    q(CPCAP_SUB_ENUM, {32'h0, 32'h6, 64'h0});
    q(CPCAP_RES_LAST, {32'hf, 32'hc000, 32'h6, 32'hf});
    q(CPCAP_RES_SECOND, {32'h7, 32'h0, 32'h4, 32'h7});
    q(32'h3, 128'h0);
    $display("test queries done");
    r(1'b0, 1'b0, CPCAP_ADDR_LL_FIRST, 64'h0, 1'b0, 64'hffff);
    r(1'b1, 1'b0, 16'h0c9f, 64'h0, 1'b0, 64'hffff);
    r(1'b0, 1'b0, 16'h0d17, 64'h0, 1'b0, 64'hff);
    r(1'b0, 1'b0, CPCAP_ADDR_ASSOC, 64'h0, 1'b0, 64'h0);
    $display("test reset values done");
    for (i = 0; i < 4; i++)
    begin
      k = $urandom_range(15, 2);
      d = 64'($urandom_range(16'hffff));
      r(1'b0, 1'b1, CPCAP_ADDR_LL_FIRST + 16'(k), d, 1'b0, 64'h0);
      r(1'b1, 1'b0, CPCAP_ADDR_LL_FIRST + 16'(k), 64'h0, 1'b0, d);
      d = 64'($urandom_range(8'hff));
      r(1'b1, 1'b1, CPCAP_ADDR_SL_FIRST + 16'(k % 8), d, 1'b0, 64'h0);
      r(1'b0, 1'b0, CPCAP_ADDR_SL_FIRST + 16'(k % 8), 64'h0, 1'b0, d);
    end
    $display("test shared masks done");
    r(1'b0, 1'b1, 16'h0ca0, 64'h1, 1'b1, 64'h0);
    r(1'b0, 1'b0, 16'h0d18, 64'h0, 1'b1, 64'h0);
    r(1'b0, 1'b0, 16'h0d50, 64'h0, 1'b1, 64'h0);
    r(1'b0, 1'b1, 16'h0c91, 64'h1_0000, 1'b1, 64'h0);
    r(1'b1, 1'b0, 16'h0c91, 64'h0, 1'b0, 64'hffff);
    $display("test refusals done");
    c = 32'($urandom_range(15, 1));
    r(1'b1, 1'b1, CPCAP_ADDR_ASSOC, {c, 32'h0}, 1'b0, 64'h0);
    `CHK("class lp1", c, lp_class_of_service[1])
    `CHK("class lp0", 32'h0, lp_class_of_service[0])
    r(1'b1, 1'b1, CPCAP_ADDR_ASSOC, 64'h1, 1'b1, 64'h0);
    r(1'b1, 1'b0, CPCAP_ADDR_ASSOC, 64'h0, 1'b0, {c, 32'h0});
    $display("test association done");
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule : tb
